// ===== hdl/flash_reg_pkg.sv
/* flash_reg_pkg: opcodes, link modes, register map, field positions,
   reset values and state type of the serial flash register engine.
   Assumes a 40 MHz system clock and one AHB-Lite register port. */
package flash_reg_pkg;
	// ---------------------------------------------------------------
	// timing and counts
	// ---------------------------------------------------------------
	localparam int         CLK_PERIOD_NS = 25;
	localparam logic [4:0] BYTE_BITS     = 5'h08;
	localparam logic [4:0] NVCR_BITS     = 5'h10;
	localparam logic [4:0] CNT_SAT       = 5'h18;
	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_CLR_FLAGS  = 8'h50;
	localparam logic [7:0] OP_RD_STATUS  = 8'h05;
	localparam logic [7:0] OP_RD_FLAGS   = 8'h70;
	localparam logic [7:0] OP_RD_NVCFG   = 8'hB5;
	localparam logic [7:0] OP_RD_VCFG    = 8'h85;
	localparam logic [7:0] OP_RD_EVCFG   = 8'h65;
	localparam logic [7:0] OP_RD_EXTADR  = 8'hC8;
	localparam logic [7:0] OP_WR_STATUS  = 8'h01;
	localparam logic [7:0] OP_WR_NVCFG   = 8'hB1;
	localparam logic [7:0] OP_WR_VCFG    = 8'h81;
	localparam logic [7:0] OP_WR_EVCFG   = 8'h61;
	localparam logic [7:0] OP_WR_EXTADR  = 8'hC5;
	localparam logic [7:0] OP_QIO_WORD   = 8'hE7;
	localparam logic [7:0] OP_DTR_FAST   = 8'h0D;
	localparam logic [7:0] OP_DTR_DOUT   = 8'h3D;
	localparam logic [7:0] OP_DTR_DIO    = 8'hBD;
	localparam logic [7:0] OP_DTR_QOUT   = 8'h6D;
	localparam logic [7:0] OP_DTR_QIO    = 8'hED;
	// ---------------------------------------------------------------
	// link modes and address-phase bases
	// ---------------------------------------------------------------
	localparam logic [1:0] MODE_EXT      = 2'h0;
	localparam logic [1:0] MODE_DUAL     = 2'h1;
	localparam logic [1:0] MODE_QUAD     = 2'h2;
	localparam logic [7:0] CX_BASE_EXT   = 8'h07;
	localparam logic [7:0] CX_BASE_DUAL  = 8'h03;
	localparam logic [7:0] CX_BASE_QUAD  = 8'h01;
	// ---------------------------------------------------------------
	// register map, fields, reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATE    = 8'h04;
	localparam logic [7:0] ADDR_CONF     = 8'h08;
	localparam logic [7:0] ADDR_EXTADR   = 8'h0C;
	localparam int         CTRL_TOP_LSB  = 8;
	localparam int         CTRL_QRY_LSB  = 16;
	localparam int         SR_LOCK_BIT   = 5;
	localparam logic [4:0] TOP_RST       = 5'h17;
	localparam logic [15:0] NVCFG_RST    = 16'hFFFF;
	localparam logic [7:0] VCFG_RST      = 8'hFB;
	localparam logic [7:0] VCFG_RSVD     = 8'h04;
	localparam logic [7:0] EVCFG_RST     = 8'hFF;
	localparam logic [7:0] EXTADR_RST    = 8'h00;
	// ---------------------------------------------------------------
	// link state, gray along idle-opcode-data, not into send
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		LS_IDLE   = 3'h0,
		LS_OPCODE = 3'h1,
		LS_DATA   = 3'h3,
		LS_SEND   = 3'h2,
		LS_TAIL   = 3'h6,
		LS_SKIP   = 3'h7
	} link_state_t;
endpackage : flash_reg_pkg

// ===== hdl/flash_reg_engine.sv
/* flash_reg_engine: command engine of a serial NOR flash for write
   enable/disable, flag clear, register reads and register writes, plus
   address-phase clock counts of double-edge and word reads.
   Assumes select, link clock and data lines synchronous to clk, with the
   link clock well below clk/2 and select low one clk before its first
   rise. Software reaches the control register over AHB-Lite. */
// Function
// - word read address end clock count
// - double-edge fast read address end count
// - double-edge dual output address end count
// - double-edge dual io address end count
// - double-edge quad output address end count
// - double-edge quad io address end count
// - select rises right after eighth opcode bit
// - extra clocks cancel enable/disable silently
// - 06h sets, 04h clears enable latch unless protection error is set
// - protection error survives disable; flag clear resets
// - output lanes by mode, select ends read
// - decode the six register read opcodes
// - status and flags readable during writes
// - nonvolatile config: low byte first, then high byte, then zeros
// - other config registers repeat same byte
// - misaligned write end cancels, latch kept
// - status and nvcfg writes are self-timed
// - status write updates bits 7:2 only
// - busy during write, then latch cleared
// - volatile config immediate, reserved bits kept
// - two-byte nvcfg write; evcfg and extaddr writes
// - 50h clears protection error flag
`timescale 1ns/1ps
module flash_reg_engine #(
	parameter int STATUS_WRITE_TIME_NS         = 1000,
	parameter int NONVOLATILE_CONFIG_WRITE_TIME_NS = 2000
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// serial link
	input  wire logic        select_n,
	input  wire logic        link_clk,
	input  wire logic [3:0]  serial_line_in,
	output logic      [3:0]  serial_line_out,
	output logic      [3:0]  serial_line_oe,
	input  wire logic        write_protect_n
);
	import flash_reg_pkg::*;

	localparam int SR_CYC = (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int NV_CYC = (NONVOLATILE_CONFIG_WRITE_TIME_NS
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] addr_end_clock(input logic [7:0] op,
		input logic [1:0] md, input logic [4:0] top);
		logic [5:0] n;
		logic [1:0] s;
		logic [7:0] base;
		n = {1'b0, top} + 6'h01;
		s = 2'h0;
		base = CX_BASE_EXT;
		unique case (md)
			MODE_EXT: begin
				if (op == OP_DTR_FAST || op == OP_DTR_DOUT) s = 2'h1;
				if (op == OP_DTR_QOUT) s = 2'h1;
				if (op == OP_QIO_WORD || op == OP_DTR_DIO) s = 2'h2;
				if (op == OP_DTR_QIO) s = 2'h3;
			end
			MODE_DUAL: begin
				base = CX_BASE_DUAL;
				if (op == OP_DTR_FAST || op == OP_DTR_DOUT) s = 2'h2;
				if (op == OP_DTR_DIO) s = 2'h3;
			end
			MODE_QUAD: begin
				base = CX_BASE_QUAD;
				if (op == OP_QIO_WORD) s = 2'h2;
				if (op == OP_DTR_FAST || op == OP_DTR_QOUT) s = 2'h3;
				if (op == OP_DTR_QIO) s = 2'h3;
			end
			default: s = 2'h0;
		endcase
		return (s == 2'h0) ? 8'h00 : base + {2'h0, 6'(n >> s)};
	endfunction : addr_end_clock

	function automatic logic [2:0] lane_count(input logic [1:0] md);
		return (md == MODE_QUAD) ? 3'h4 : (md == MODE_DUAL) ? 3'h2 : 3'h1;
	endfunction : lane_count

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	link_state_t st_reg, st_next;
	logic [4:0]  cnt_reg, cnt_next, ocnt_reg, ocnt_next;
	logic [15:0] sh_reg, sh_next, shifted, nvcfg_reg, nvcfg_next;
	logic [7:0]  op_reg, op_next, obuf_reg, obuf_next, tx_byte, sel_op;
	logic [1:0]  bidx_reg, bidx_next, sel_idx;
	logic [3:0]  out_reg, out_next;
	logic        lclk_reg, rise, fall;
	logic        wel_reg, wel_next, wip_reg, wip_next, prot_reg, prot_next;
	logic [5:0]  sr_reg, sr_next;
	logic [7:0]  vcfg_reg, vcfg_next, evcfg_reg, evcfg_next;
	logic [7:0]  ear_reg, ear_next, sr_byte, flag_byte;
	logic [15:0] tmr_reg, tmr_next;
	logic [1:0]  mode_reg, mode_next;
	logic [4:0]  top_reg, top_next;
	logic [7:0]  qry_reg, qry_next, adr_reg, adr_next;
	logic        wrp_reg, wrp_next;
	logic [31:0] rdat_reg, rdat_next;
	logic [2:0]  lanes;

	// ---------------------------------------------------------------
	// link sampling and shifting, msb first
	// ---------------------------------------------------------------
	assign rise  = link_clk && !lclk_reg && !select_n;
	assign fall  = !link_clk && lclk_reg && !select_n;
	assign lanes = lane_count(mode_reg);
	always_comb begin
		unique case (mode_reg)
			MODE_DUAL: shifted = {sh_reg[13:0], serial_line_in[1:0]};
			MODE_QUAD: shifted = {sh_reg[11:0], serial_line_in[3:0]};
			default:   shifted = {sh_reg[14:0], serial_line_in[0]};
		endcase
	end
	assign sr_byte   = {sr_reg, wel_reg, wip_reg};
	assign flag_byte = {~wip_reg, 5'h00, prot_reg, 1'b0};

	// ---------------------------------------------------------------
	// register read byte source
	// ---------------------------------------------------------------
	assign sel_op  = (st_reg == LS_OPCODE) ? shifted[7:0] : op_reg;
	assign sel_idx = (st_reg == LS_OPCODE) ? 2'h0 : bidx_reg;
	always_comb begin
		unique case (sel_op)
			OP_RD_STATUS: tx_byte = sr_byte;
			OP_RD_FLAGS:  tx_byte = flag_byte;
			OP_RD_NVCFG:  tx_byte = (sel_idx == 2'h0) ? nvcfg_reg[7:0]
				: (sel_idx == 2'h1) ? nvcfg_reg[15:8] : 8'h00;
			OP_RD_VCFG:   tx_byte = vcfg_reg;
			OP_RD_EVCFG:  tx_byte = evcfg_reg;
			OP_RD_EXTADR: tx_byte = ear_reg;
			default:      tx_byte = 8'h00;
		endcase
	end

	// ---------------------------------------------------------------
	// command sequencer
	// ---------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		op_next = op_reg;
		obuf_next = obuf_reg;
		ocnt_next = ocnt_reg;
		bidx_next = bidx_reg;
		out_next = out_reg;
		wel_next = wel_reg;
		wip_next = wip_reg;
		prot_next = prot_reg;
		sr_next = sr_reg;
		nvcfg_next = nvcfg_reg;
		vcfg_next = vcfg_reg;
		evcfg_next = evcfg_reg;
		ear_next = ear_reg;
		tmr_next = tmr_reg;
		if (tmr_reg != 16'h0000) begin
			tmr_next = tmr_reg - 16'h0001;
		end else if (wip_reg) begin
			wip_next = 1'b0;
			wel_next = 1'b0;
		end
		unique case (st_reg)
			LS_IDLE: begin
				if (!select_n) begin
					st_next = LS_OPCODE;
					cnt_next = 5'h00;
					sh_next = 16'h0000;
				end
			end
			LS_OPCODE: begin
				if (select_n) begin
					st_next = LS_IDLE;
				end else if (rise) begin
					sh_next = shifted;
					cnt_next = cnt_reg + {2'h0, lanes};
					if (cnt_next == BYTE_BITS) begin
						op_next = shifted[7:0];
						cnt_next = 5'h00;
						sh_next = 16'h0000;
						unique case (shifted[7:0])
							OP_RD_STATUS, OP_RD_FLAGS, OP_RD_NVCFG,
							OP_RD_VCFG, OP_RD_EVCFG, OP_RD_EXTADR: begin
								st_next = LS_SEND;
								obuf_next = tx_byte;
								ocnt_next = 5'h00;
								bidx_next = 2'h1;
							end
							OP_WR_STATUS, OP_WR_NVCFG, OP_WR_VCFG,
							OP_WR_EVCFG, OP_WR_EXTADR: begin
								st_next = (wel_reg && !wip_reg) ? LS_DATA
									: LS_SKIP;
							end
							OP_WR_ENABLE, OP_WR_DISABLE, OP_CLR_FLAGS: begin
								st_next = LS_TAIL;
							end
							default: st_next = LS_SKIP;
						endcase
					end
				end
			end
			LS_SEND: begin
				if (select_n) begin
					st_next = LS_IDLE;
				end else if (fall) begin
					unique case (mode_reg)
						MODE_DUAL: out_next = {2'h0, obuf_reg[7:6]};
						MODE_QUAD: out_next = obuf_reg[7:4];
						default:   out_next = {2'h0, obuf_reg[7], 1'b0};
					endcase
					obuf_next = obuf_reg << lanes;
					ocnt_next = ocnt_reg + {2'h0, lanes};
					if (ocnt_next == BYTE_BITS) begin
						obuf_next = tx_byte;
						ocnt_next = 5'h00;
						if (bidx_reg != 2'h2) bidx_next = bidx_reg + 2'h1;
					end
				end
			end
			LS_DATA: begin
				if (select_n) begin
					st_next = LS_IDLE;
					if (op_reg == OP_WR_NVCFG && cnt_reg == NVCR_BITS) begin
						nvcfg_next = {sh_reg[7:0], sh_reg[15:8]};
						wip_next = 1'b1;
						tmr_next = 16'(NV_CYC);
					end else if (op_reg != OP_WR_NVCFG
						&& cnt_reg == BYTE_BITS) begin
						unique case (op_reg)
							OP_WR_STATUS: begin
								if (sr_reg[SR_LOCK_BIT] && !write_protect_n)
									prot_next = 1'b1;
								else begin
									sr_next = sh_reg[7:2];
									wip_next = 1'b1;
									tmr_next = 16'(SR_CYC);
								end
							end
							OP_WR_VCFG: begin
								vcfg_next = (vcfg_reg & VCFG_RSVD)
									| (sh_reg[7:0] & ~VCFG_RSVD);
								wel_next = 1'b0;
							end
							OP_WR_EVCFG: begin
								evcfg_next = sh_reg[7:0];
								wel_next = 1'b0;
							end
							default: begin
								ear_next = sh_reg[7:0];
								wel_next = 1'b0;
							end
						endcase
					end
				end else if (rise) begin
					sh_next = shifted;
					if (cnt_reg < CNT_SAT)
						cnt_next = cnt_reg + {2'h0, lanes};
				end
			end
			LS_TAIL: begin
				if (select_n) begin
					st_next = LS_IDLE;
					if (op_reg == OP_WR_ENABLE) wel_next = 1'b1;
					if (op_reg == OP_WR_DISABLE && !prot_reg)
						wel_next = 1'b0;
					if (op_reg == OP_CLR_FLAGS) begin
						prot_next = 1'b0;
						wel_next = 1'b0;
					end
				end else if (rise) begin
					st_next = LS_SKIP;
				end
			end
			LS_SKIP: begin
				if (select_n) st_next = LS_IDLE;
			end
			default: st_next = LS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= LS_IDLE;
			cnt_reg <= 5'h00;
			sh_reg <= 16'h0000;
			op_reg <= 8'h00;
			obuf_reg <= 8'h00;
			ocnt_reg <= 5'h00;
			bidx_reg <= 2'h0;
			out_reg <= 4'h0;
			lclk_reg <= 1'b0;
			wel_reg <= 1'b0;
			wip_reg <= 1'b0;
			prot_reg <= 1'b0;
			sr_reg <= 6'h00;
			nvcfg_reg <= NVCFG_RST;
			vcfg_reg <= VCFG_RST;
			evcfg_reg <= EVCFG_RST;
			ear_reg <= EXTADR_RST;
			tmr_reg <= 16'h0000;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			op_reg <= op_next;
			obuf_reg <= obuf_next;
			ocnt_reg <= ocnt_next;
			bidx_reg <= bidx_next;
			out_reg <= out_next;
			lclk_reg <= link_clk;
			wel_reg <= wel_next;
			wip_reg <= wip_next;
			prot_reg <= prot_next;
			sr_reg <= sr_next;
			nvcfg_reg <= nvcfg_next;
			vcfg_reg <= vcfg_next;
			evcfg_reg <= evcfg_next;
			ear_reg <= ear_next;
			tmr_reg <= tmr_next;
		end
	end

	assign serial_line_out = out_reg;
	assign serial_line_oe  = (st_reg != LS_SEND || select_n) ? 4'h0
		: (mode_reg == MODE_QUAD) ? 4'hF
		: (mode_reg == MODE_DUAL) ? 4'h3 : 4'h2;

	// ---------------------------------------------------------------
	// ahb-lite register port, zero wait
	// ---------------------------------------------------------------
	always_comb begin
		mode_next = mode_reg;
		top_next = top_reg;
		qry_next = qry_reg;
		adr_next = adr_reg;
		wrp_next = 1'b0;
		rdat_next = 32'h0000_0000;
		if (wrp_reg && adr_reg == ADDR_CTRL) begin
			mode_next = hwdata[1:0];
			top_next = hwdata[CTRL_TOP_LSB +: 5];
			qry_next = hwdata[CTRL_QRY_LSB +: 8];
		end
		if (hsel && htrans[1] && hready) begin
			adr_next = haddr[7:0];
			wrp_next = hwrite;
			if (!hwrite) begin
				unique case (haddr[7:0])
					ADDR_CTRL:   rdat_next = {addr_end_clock(qry_reg,
						mode_reg, top_reg), qry_reg, 3'h0, top_reg,
						6'h00, mode_reg};
					ADDR_STATE:  rdat_next = {16'h0000, flag_byte, sr_byte};
					ADDR_CONF:   rdat_next = {evcfg_reg, vcfg_reg, nvcfg_reg};
					ADDR_EXTADR: rdat_next = {24'h00_0000, ear_reg};
					default:     rdat_next = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= MODE_EXT;
			top_reg <= TOP_RST;
			qry_reg <= 8'h00;
			adr_reg <= 8'h00;
			wrp_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			mode_reg <= mode_next;
			top_reg <= top_next;
			qry_reg <= qry_next;
			adr_reg <= adr_next;
			wrp_reg <= wrp_next;
			rdat_reg <= rdat_next;
		end
	end

	assign hrdata    = rdat_reg;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_wel_set_enable: assert property (
		select_n && st_reg == LS_TAIL && op_reg == OP_WR_ENABLE
		|=> wel_reg && st_reg == LS_IDLE)
		else $error("enable did not set latch");
	a_wel_prot_hold: assert property (
		select_n && st_reg == LS_TAIL && op_reg == OP_WR_DISABLE
		&& prot_reg |=> wel_reg)
		else $error("disable cleared latch under protection");
	a_flag_clear_all: assert property (
		select_n && st_reg == LS_TAIL && op_reg == OP_CLR_FLAGS
		|=> !prot_reg && !wel_reg)
		else $error("flag clear left bits set");
	a_skip_no_effect: assert property (
		st_reg == LS_SKIP && select_n && !wip_reg
		|=> $stable(wel_reg) && $stable(prot_reg) && $stable(sr_reg))
		else $error("cancelled command changed state");
	a_status_hi_bits: assert property (
		select_n && st_reg == LS_DATA && op_reg == OP_WR_STATUS
		&& cnt_reg == BYTE_BITS && !prot_next
		|=> sr_reg == $past(sh_reg[7:2]) && wip_reg)
		else $error("status write wrong");
	a_busy_then_free: assert property (
		$fell(wip_reg) |-> !wel_reg)
		else $error("latch set after write completion");
	a_busy_holds: assert property (
		$rose(wip_reg) |-> wip_reg[*8])
		else $error("write time too short");
	a_ext_out_lane: assert property (
		st_reg == LS_SEND && mode_reg == MODE_EXT && fall
		|-> serial_line_oe == 4'h2
		##1 serial_line_out == {2'h0, $past(obuf_reg[7]), 1'b0})
		else $error("extended read drives wrong line");
	a_select_stops: assert property (
		select_n |-> serial_line_oe == 4'h0 ##1 st_reg != LS_SEND)
		else $error("read not ended by select");
	// reload after the high byte and every later one must be zero
	a_nv_zero_tail: assert property (
		st_reg == LS_SEND && op_reg == OP_RD_NVCFG && bidx_reg == 2'h2
		&& fall && ocnt_next == 5'h00 |=> obuf_reg == 8'h00)
		else $error("nvcfg tail not zero");

	c_enable: cover property (select_n && st_reg == LS_TAIL
		&& op_reg == OP_WR_ENABLE);
	c_status_read: cover property (st_reg == LS_SEND
		&& op_reg == OP_RD_STATUS && ocnt_next == 5'h00 && fall);
	c_nv_done: cover property ($fell(wip_reg) ##1 st_reg == LS_IDLE);
	c_cancel: cover property (st_reg == LS_SKIP && select_n);
endmodule : flash_reg_engine

// ===== sim/link_host.sv
/* link_host: behavioural host controller on the serial link.
   Assumes the bench sets md to the mode written into the engine. */
`timescale 1ns/1ps
module link_host (
	// system clock
	input  wire logic       clk,
	// serial link
	output logic            select_n,
	output logic            link_clk,
	output logic      [3:0] serial_line_in,
	input  wire logic [3:0] serial_line_out,
	input  wire logic [3:0] serial_line_oe
);
	import flash_reg_pkg::*;

	logic [3:0]  drv;
	logic [1:0]  md;
	logic [23:0] rx;
	logic [3:0]  seen_oe;

	initial begin
		select_n = 1'b1;
		link_clk = 1'b0;
		drv = 4'h0;
		md = MODE_EXT;
	end
	// lanes the engine enables carry its bits
	assign serial_line_in = (serial_line_oe & serial_line_out) |
		(~serial_line_oe & drv);

	// ---------------------------------------------------------------
	// one link clock period
	// ---------------------------------------------------------------
	task automatic beat(input logic [3:0] d);
		@(posedge clk);
		drv <= d;
		repeat (2) @(posedge clk);
		seen_oe = serial_line_oe;
		case (md)
			MODE_EXT:  rx = {rx[22:0], serial_line_in[1]};
			MODE_DUAL: rx = {rx[21:0], serial_line_in[1:0]};
			default:   rx = {rx[19:0], serial_line_in};
		endcase
		link_clk <= 1'b1;
		repeat (2) @(posedge clk);
		link_clk <= 1'b0;
	endtask : beat

	// ---------------------------------------------------------------
	// one framed command
	// ---------------------------------------------------------------
	task automatic frame(input logic [7:0] op, input logic [15:0] d,
		input int nd, input int nr, input int xb);
		int w;
		w = (md == MODE_EXT) ? 1 : (md == MODE_DUAL) ? 2 : 4;
		@(posedge clk);
		select_n <= 1'b0;
		for (int i = 8 - w; i >= 0; i -= w)
			beat(4'(op >> i));
		for (int b = 0; b < nd; b++)
			for (int i = 8 - w; i >= 0; i -= w)
				beat(4'(d >> (8 * b + i)));
		repeat (nr * 8 / w + xb) beat(~drv);
		@(posedge clk);
		select_n <= 1'b1;
		drv <= ~drv;
		repeat (3) @(posedge clk);
	endtask : frame
endmodule : link_host

// ===== sim/tb_serial_flash_register_access.sv
/* tb_serial_flash_register_access: self-checking bench of the engine.
   Assumes link_host on the link and a zero-wait AHB-Lite slave. */
`timescale 1ns/1ps
module tb_serial_flash_register_access;
	import flash_reg_pkg::*;
	typedef struct {
		logic [7:0]  op;
		logic [1:0]  md;
		int          div;
		int          nr;
		logic [23:0] exp;
	} row_t;
	logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, wp_n;
	logic        select_n, link_clk;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  line_in, line_out, line_oe;
	logic [4:0]  top;
	logic [7:0]  cx;
	logic [31:0] haddr, hwdata, hrdata, rd, m, ctl;
	int          err_count, checks;
	row_t        rows [21] = '{
		'{OP_QIO_WORD,MODE_EXT,4,0,0}, '{OP_QIO_WORD,MODE_QUAD,4,0,0},
		'{OP_QIO_WORD,MODE_DUAL,0,0,0}, '{OP_DTR_FAST,MODE_EXT,2,0,0},
		'{OP_DTR_FAST,MODE_DUAL,4,0,0}, '{OP_DTR_FAST,MODE_QUAD,8,0,0},
		'{OP_DTR_DOUT,MODE_EXT,2,0,0}, '{OP_DTR_DOUT,MODE_DUAL,4,0,0},
		'{OP_DTR_DOUT,MODE_QUAD,0,0,0}, '{OP_DTR_DIO,MODE_EXT,4,0,0},
		'{OP_DTR_DIO,MODE_DUAL,8,0,0}, '{OP_DTR_QOUT,MODE_EXT,2,0,0},
		'{OP_DTR_QOUT,MODE_QUAD,8,0,0}, '{OP_DTR_QIO,MODE_EXT,8,0,0},
		'{OP_DTR_QIO,MODE_QUAD,8,0,0}, '{OP_RD_STATUS,MODE_EXT,0,1,0},
		'{OP_RD_FLAGS,MODE_EXT,0,1,24'h80},
		'{OP_RD_NVCFG,MODE_EXT,0,3,24'hFF_FF00},
		'{OP_RD_VCFG,MODE_EXT,0,2,24'hFBFB},
		'{OP_RD_EVCFG,MODE_EXT,0,2,24'hFFFF},
		'{OP_RD_EXTADR,MODE_EXT,0,2,0}};

	flash_reg_engine #(
		.STATUS_WRITE_TIME_NS            (250),
		.NONVOLATILE_CONFIG_WRITE_TIME_NS(4000)
	) dut (
		.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .select_n(select_n),
		.link_clk(link_clk), .serial_line_in(line_in),
		.serial_line_out(line_out), .serial_line_oe(line_oe),
		.write_protect_n(wp_n));
	link_host host (
		.clk(clk), .select_n(select_n), .link_clk(link_clk),
		.serial_line_in(line_in), .serial_line_out(line_out),
		.serial_line_oe(line_oe));

	// ---------------------------------------------------------------
	// report, compare and bus tasks
	// ---------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	task automatic bail();
		err_count++;
		$display("CHECK FAILED t=%0t wait ran out", $time);
		complete_run();
	endtask : bail

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic ready_edge();
		@(posedge clk);
		for (int n = 0; hreadyout !== 1'b1; n++) begin
			if (n == 20)
				bail();
			@(posedge clk);
		end
	endtask : ready_edge

	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		ready_edge();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		ready_edge();
		rd = hrdata;
	endtask : ahb

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk(32'(hresp), 32'h0);
	endtask : rchk

	task automatic cmd(input logic [7:0] o, input logic [15:0] d = 0,
		input int nd = 0, input int xb = 0);
		host.frame(o, d, nd, 0, xb);
	endtask : cmd

	task automatic wait_idle();
		for (int n = 0; n < 100; n++) begin
			ahb(1'b0, ADDR_STATE, 32'h0);
			if (rd[0] === 1'b0)
				return;
		end
		bail();
	endtask : wait_idle

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		wp_n = 1'b1;
		err_count = 0;
		checks = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk(ADDR_CONF, 32'hFFFB_FFFF);
		ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
		rchk(8'h40, 32'h0);
		foreach (rows[i]) begin
			top = (i % 2 == 1) ? 5'h1F : 5'h17;
			cx = (rows[i].md == MODE_EXT) ? CX_BASE_EXT :
				(rows[i].md == MODE_DUAL) ? CX_BASE_DUAL : CX_BASE_QUAD;
			if (rows[i].div != 0)
				cx = cx + 8'((32'(top) + 1) / rows[i].div);
			else
				cx = 8'h00;
			ctl = {8'h00, rows[i].op, 3'h0, top, 6'h00, rows[i].md};
			ahb(1'b1, ADDR_CTRL, ctl);
			if (rows[i].nr == 0)
				rchk(ADDR_CTRL, {cx, ctl[23:0]});
			else begin
				host.frame(rows[i].op, 16'h0, 0, rows[i].nr, 0);
				m = (32'h1 << (8 * rows[i].nr)) - 32'h1;
				chk({8'h0, host.rx} & m, {8'h0, rows[i].exp});
				chk(32'(host.seen_oe), 32'h2);
				chk(32'(line_oe), 32'h0);
			end
		end
		cmd(OP_WR_ENABLE, 0, 0, 1);
		rchk(ADDR_STATE, 32'h0000_8000);
		cmd(OP_WR_ENABLE);
		rchk(ADDR_STATE, 32'h0000_8002);
		cmd(OP_WR_VCFG, 16'h0000, 1, 1);
		rchk(ADDR_STATE, 32'h0000_8002);
		cmd(OP_WR_VCFG, 16'h00FF, 1);
		cmd(OP_WR_ENABLE);
		cmd(OP_WR_EVCFG, 16'h003C, 1);
		cmd(OP_WR_ENABLE);
		cmd(OP_WR_EXTADR, 16'h005A, 1);
		rchk(ADDR_CONF, 32'h3CFB_FFFF);
		rchk(ADDR_EXTADR, 32'h0000_005A);
		host.frame(OP_RD_EXTADR, 16'h0, 0, 2, 0);
		chk(32'(host.rx[15:0]), 32'h0000_5A5A);
		cmd(OP_WR_ENABLE);
		cmd(OP_WR_DISABLE);
		rchk(ADDR_STATE, 32'h0000_8000);
		cmd(OP_WR_ENABLE);
		cmd(OP_WR_NVCFG, 16'h1234, 2);
		host.frame(OP_RD_STATUS, 16'h0, 0, 1, 0);
		chk(32'(host.rx[0]), 32'h1);
		ahb(1'b0, ADDR_STATE, 32'h0);
		chk(rd & 32'h0000_8001, 32'h0000_0001);
		wait_idle();
		rchk(ADDR_STATE, 32'h0000_8000);
		host.frame(OP_RD_NVCFG, 16'h0, 0, 3, 0);
		chk(32'(host.rx), 32'h0034_1200);
		cmd(OP_WR_ENABLE);
		cmd(OP_WR_STATUS, 16'h00FF, 1);
		wait_idle();
		rchk(ADDR_STATE, 32'h0000_80FC);
		wp_n <= 1'b0;
		cmd(OP_WR_ENABLE);
		cmd(OP_WR_STATUS, 16'h0000, 1);
		cmd(OP_WR_DISABLE);
		rchk(ADDR_STATE, 32'h0000_82FE);
		cmd(OP_CLR_FLAGS);
		rchk(ADDR_STATE, 32'h0000_80FC);
		wp_n <= 1'b1;
		for (int k = 1; k < 3; k++) begin
			ahb(1'b1, ADDR_CTRL, 32'(k));
			host.md = 2'(k);
			cmd(OP_WR_ENABLE);
			host.frame(OP_RD_STATUS, 16'h0, 0, 1, 0);
			chk(32'(host.rx[7:0]), 32'h0000_00FE);
			chk(32'(host.seen_oe), (k == 1) ? 32'h3 : 32'hF);
			cmd(OP_WR_DISABLE);
		end
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		host.md = MODE_EXT;
		rchk(ADDR_CTRL, 32'h0000_1700);
		rchk(ADDR_STATE, 32'h0000_8000);
		complete_run();
	end
endmodule : tb_serial_flash_register_access
